// *** design/sdi_pkg.sv ***
// Purpose: shared constants and carriers for the digital input function decoder
// Assumes: inputs synchronous to clk, active high
// Notes: stored positions held as 32-bit counts
package sdi_pkg;
   localparam int POS_W = 32;
   localparam int SPEED_W = 16;
   localparam int NUM_POS = 8;
   localparam logic [1:0] CLR_DEVIATION = 2'h0;
   localparam logic [1:0] CLR_FEEDBACK = 2'h1;
   localparam logic [1:0] CLR_ABORT = 2'h2;
   localparam logic [1:0] CLR_ABORT_REACH = 2'h3;
   localparam logic [2:0] SEL_RESET = 3'h0;

   typedef enum logic [1:0] {
      SDI_MODE_EXT_PULSE,
      SDI_MODE_INT_POS,
      SDI_MODE_SPEED,
      SDI_MODE_TORQUE
   } sdi_mode_e;

   typedef struct packed {
      logic clear_deviation;
      logic clear_feedback;
      logic abort_motion;
   } sdi_clear_s;

   typedef struct packed {
      logic start_move;
      logic [2:0] select;
      logic [POS_W-1:0] target;
   } sdi_move_s;
endpackage

// *** design/sdi_input_functions.sv ***
// Purpose: decode assignable digital inputs into motion core actions
// Assumes: one clock, inputs synchronous, stored positions supplied by core
// Notes: action outputs are registered one-cycle pulses or levels
`timescale 1ns/1ps

// Notes on behaviour
// - pulse clear performs selected clear mode action
// - mode 0 clears deviation, position modes
// - mode 1 clears feedback and revolutions
// - mode 2 aborts motion, internal position only
// - mode 3 aborts, reached after stop
// - zero-speed lock holds position below threshold
// - invert reverses rotation in internal pos/speed/torque, not in external pulse mode
// - pause halts internal position command
// - trigger rising edge starts stored move
// - torque limit effective in speed/position
// - speed limit effective in torque mode
// - three selects choose one of eight
// - select decoded binary, all off first
module sdi_input_functions (
   input wire logic clk, // 40 MHz clock
   input wire logic rst, // async reset, high
   input wire sdi_pkg::sdi_mode_e control_mode, // active control mode
   input wire logic [1:0] clear_mode_setting, // pulse clear mode
   input wire logic pulse_clear_input, // pulse clear
   input wire logic zero_speed_lock_input, // zero speed lock
   input wire logic command_invert_input, // invert command
   input wire logic pause_input, // pause internal command
   input wire logic command_trigger_input, // trigger stored move
   input wire logic torque_limit_enable_input, // torque limit enable
   input wire logic speed_limit_enable_input, // speed limit enable
   input wire logic position_select_bit0, // select lsb
   input wire logic position_select_bit1, // select middle
   input wire logic position_select_bit2, // select msb
   input wire logic [sdi_pkg::SPEED_W-1:0] motor_speed, // speed magnitude
   input wire logic [sdi_pkg::SPEED_W-1:0] zero_speed_threshold, // lock threshold
   input wire logic motor_stopped, // core reports standstill
   input wire logic [sdi_pkg::NUM_POS*sdi_pkg::POS_W-1:0] stored_positions, // table
   output sdi_pkg::sdi_clear_s clear_out, // clear pulses
   output sdi_pkg::sdi_move_s move_out, // move request
   output logic position_reached_output, // reached after clear mode 3
   output logic hold_position, // zero speed lock active
   output logic invert_direction, // reverse rotation
   output logic command_paused, // internal command paused
   output logic torque_limit_active, // torque limit effective
   output logic speed_limit_active // speed limit effective
);
   import sdi_pkg::*;

   // ==========================================================
   // mode qualifiers
   logic pos_modes;
   logic in_int_pos;
   logic clear_prev_reg;
   logic trig_prev_reg;
   logic clear_edge;
   logic trig_edge;
   logic wait_stop_reg;
   logic [2:0] sel;
   logic [POS_W-1:0] pos_table [NUM_POS];

   assign in_int_pos = (control_mode == SDI_MODE_INT_POS);
   assign pos_modes = in_int_pos || (control_mode == SDI_MODE_EXT_PULSE);
   assign clear_edge = pulse_clear_input && !clear_prev_reg;
   assign trig_edge = command_trigger_input && !trig_prev_reg;
   assign sel = {position_select_bit2, position_select_bit1, position_select_bit0};

   genvar gi;
   generate
      for (gi = 0; gi < NUM_POS; gi++) begin : g_tab
         assign pos_table[gi] = stored_positions[gi*POS_W +: POS_W];
      end
   endgenerate

   // ==========================================================
   // edge history
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clear_prev_reg <= 1'b0;
         trig_prev_reg <= 1'b0;
      end else begin
         clear_prev_reg <= pulse_clear_input;
         trig_prev_reg <= command_trigger_input;
      end
   end

   // ==========================================================
   // pulse clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clear_out <= '0;
      end else begin
         clear_out <= '0;
         if (clear_edge) begin
            unique case (clear_mode_setting)
               CLR_DEVIATION: clear_out.clear_deviation <= pos_modes;
               CLR_FEEDBACK: clear_out.clear_feedback <= pos_modes;
               CLR_ABORT: clear_out.abort_motion <= in_int_pos;
               CLR_ABORT_REACH: clear_out.abort_motion <= in_int_pos;
            endcase
         end
      end
   end

   // wait for standstill then flag reached
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_stop_reg <= 1'b0;
         position_reached_output <= 1'b0;
      end else begin
         if (clear_edge && in_int_pos && clear_mode_setting == CLR_ABORT_REACH) begin
            wait_stop_reg <= 1'b1;
            position_reached_output <= 1'b0;
         end else if (wait_stop_reg && motor_stopped) begin
            wait_stop_reg <= 1'b0;
            position_reached_output <= 1'b1;
         end else if (move_out.start_move) begin
            position_reached_output <= 1'b0;
         end
      end
   end

   // ==========================================================
   // triggered move
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         move_out <= '0;
         move_out.select <= SEL_RESET;
      end else begin
         move_out.start_move <= trig_edge && in_int_pos;
         if (trig_edge && in_int_pos) begin
            move_out.select <= sel;
            move_out.target <= pos_table[sel];
         end
      end
   end

   // ==========================================================
   // level functions
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_position <= 1'b0;
         invert_direction <= 1'b0;
         command_paused <= 1'b0;
         torque_limit_active <= 1'b0;
         speed_limit_active <= 1'b0;
      end else begin
         hold_position <= zero_speed_lock_input && (motor_speed < zero_speed_threshold);
         invert_direction <= command_invert_input && (control_mode != SDI_MODE_EXT_PULSE);
         command_paused <= pause_input && in_int_pos;
         torque_limit_active <= torque_limit_enable_input
            && (control_mode != SDI_MODE_TORQUE);
         speed_limit_active <= speed_limit_enable_input
            && (control_mode == SDI_MODE_TORQUE);
      end
   end

   // ==========================================================
   // checks
   AST_CLR_DEV: assert property (@(posedge clk) disable iff (rst)
      (clear_edge && pos_modes && clear_mode_setting == CLR_DEVIATION)
      |=> clear_out.clear_deviation)
      else $error("deviation clear missing");
   AST_CLR_FB: assert property (@(posedge clk) disable iff (rst)
      (clear_edge && pos_modes && clear_mode_setting == CLR_FEEDBACK)
      |=> clear_out.clear_feedback && !clear_out.clear_deviation)
      else $error("feedback clear missing");
   AST_ABORT: assert property (@(posedge clk) disable iff (rst)
      clear_out.abort_motion |-> $past(in_int_pos) && $past(clear_mode_setting[1]))
      else $error("abort outside internal position");
   AST_REACH: assert property (@(posedge clk) disable iff (rst)
      $rose(position_reached_output) |-> $past(wait_stop_reg) && $past(motor_stopped))
      else $error("reached without stop");
   AST_LOCK: assert property (@(posedge clk) disable iff (rst)
      (zero_speed_lock_input && motor_speed < zero_speed_threshold) |=> hold_position)
      else $error("lock not held");
   AST_INV: assert property (@(posedge clk) disable iff (rst)
      (control_mode == SDI_MODE_EXT_PULSE) |=> !invert_direction)
      else $error("invert in pulse mode");
   AST_PAUSE: assert property (@(posedge clk) disable iff (rst)
      (pause_input && in_int_pos) |=> command_paused)
      else $error("pause not applied");
   // trigger already high at reset release counts as an edge
   AST_TRIG: assert property (@(posedge clk) disable iff (rst)
      move_out.start_move |-> $past(command_trigger_input)
      && (!$past(command_trigger_input, 2) || $past(rst, 2)))
      else $error("move without rising edge");
   AST_SEL: assert property (@(posedge clk) disable iff (rst)
      move_out.start_move |-> move_out.select == $past(sel)
      && move_out.target == $past(pos_table[sel]))
      else $error("wrong stored position");
   AST_LIM: assert property (@(posedge clk) disable iff (rst)
      speed_limit_active |-> !torque_limit_active)
      else $error("both limits active");

   // ==========================================================
   // refusals and held values
   AST_NO_CLR: assert property (@(posedge clk) disable iff (rst)
      (clear_edge && !pos_modes) |=> clear_out == '0)
      else $error("clear outside position modes");
   AST_ABORT_REQ: assert property (@(posedge clk) disable iff (rst)
      (clear_edge && in_int_pos && clear_mode_setting[1]) |=> clear_out.abort_motion)
      else $error("abort missing");
   AST_REACH_CLR: assert property (@(posedge clk) disable iff (rst)
      (clear_edge && in_int_pos && clear_mode_setting == CLR_ABORT_REACH)
      |=> !position_reached_output)
      else $error("reached not withdrawn on abort");
   AST_LOCK_OFF: assert property (@(posedge clk) disable iff (rst)
      !zero_speed_lock_input |=> !hold_position)
      else $error("lock without input");
   AST_INV_ON: assert property (@(posedge clk) disable iff (rst)
      (command_invert_input && control_mode != SDI_MODE_EXT_PULSE) |=> invert_direction)
      else $error("invert not applied");
   AST_PAUSE_OFF: assert property (@(posedge clk) disable iff (rst)
      !in_int_pos |=> !command_paused)
      else $error("pause outside internal position");
   AST_NO_MOVE: assert property (@(posedge clk) disable iff (rst)
      (command_trigger_input && !in_int_pos) |=> !move_out.start_move)
      else $error("move outside internal position");
   AST_TRQ: assert property (@(posedge clk) disable iff (rst)
      (torque_limit_enable_input && control_mode != SDI_MODE_TORQUE) |=> torque_limit_active)
      else $error("torque limit not applied");
   AST_SPD: assert property (@(posedge clk) disable iff (rst)
      (speed_limit_enable_input && control_mode == SDI_MODE_TORQUE) |=> speed_limit_active)
      else $error("speed limit not applied");
   AST_SEL_HOLD: assert property (@(posedge clk) disable iff (rst)
      !move_out.start_move |-> $stable(move_out.select) && $stable(move_out.target))
      else $error("move request changed without trigger");
   AST_SEL0: assert property (@(posedge clk) disable iff (rst)
      (move_out.start_move && move_out.select == 3'h0)
      |-> move_out.target == $past(stored_positions[POS_W-1:0]))
      else $error("all-off select not first entry");
endmodule

// *** sim/sdi_ctrl_model.sv ***
// Purpose: external controller driving select and trigger inputs
// Assumes: bench calls fire then drop
// Notes: selects settle one cycle before trigger rises
`timescale 1ns/1ps
module sdi_ctrl_model (
   input wire logic clk, // clock
   output logic trig, // trigger line
   output logic [2:0] sel // select bits
);
   // ==========
   // drive
   initial begin
      trig = 1'b0;
      sel = 3'h0;
   end
   task automatic fire(input logic [2:0] s);
      sel = s;
      @(posedge clk);
      #2 trig = 1'b1;
   endtask
   task automatic drop();
      trig = 1'b0;
   endtask
endmodule

// *** sim/sdi_input_functions_tb.sv ***
// Purpose: self-checking bench for input function decoder
// Assumes: inputs driven 2 ns after rising edge
// Notes: lfsr seeded 9132
`timescale 1ns/1ps
module sdi_input_functions_tb;
   import sdi_pkg::*;
   // ==========
   // signals
   logic clk = 1'b0, rst = 1'b1, stp = 1'b0, clr = 1'b0;
   logic lck = 1'b0, inv = 1'b0, pau = 1'b0, tle = 1'b0, sle = 1'b0;
   logic [1:0] cm = 2'h0;
   logic [SPEED_W-1:0] spd = 16'h0000, thr = 16'h0010;
   logic [NUM_POS*POS_W-1:0] tab;
   logic [15:0] lf = 16'h23AC;
   logic [2:0] sel, s;
   logic trg, rch, hld, ivd, cpa, tla, sla;
   sdi_mode_e md = SDI_MODE_INT_POS;
   sdi_clear_s co;
   sdi_move_s mo;
   int error_cnt = 0, n_checks = 0;
   always #12.5 clk = ~clk;
   sdi_ctrl_model m (.clk(clk), .trig(trg), .sel(sel));
   sdi_input_functions dut (.clk(clk), .rst(rst), .control_mode(md),
      .clear_mode_setting(cm), .pulse_clear_input(clr), .zero_speed_lock_input(lck),
      .command_invert_input(inv), .pause_input(pau), .command_trigger_input(trg),
      .torque_limit_enable_input(tle), .speed_limit_enable_input(sle),
      .position_select_bit0(sel[0]), .position_select_bit1(sel[1]),
      .position_select_bit2(sel[2]), .motor_speed(spd), .zero_speed_threshold(thr),
      .motor_stopped(stp), .stored_positions(tab), .clear_out(co), .move_out(mo),
      .position_reached_output(rch), .hold_position(hld), .invert_direction(ivd),
      .command_paused(cpa), .torque_limit_active(tla), .speed_limit_active(sla));
   // ==========
   // helpers
   function automatic logic [15:0] nx(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [2:0] exp_clr(input sdi_mode_e d, input logic [1:0] c);
      logic pz;
      pz = d == SDI_MODE_EXT_PULSE || d == SDI_MODE_INT_POS;
      return {pz && c == CLR_DEVIATION, pz && c == CLR_FEEDBACK, d == SDI_MODE_INT_POS && c[1]};
   endfunction
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task automatic tick();
      @(posedge clk);
      #2;
   endtask
   task automatic end_sim();
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #20000;
      error_cnt++;
      end_sim();
   end
   // ==========
   // scenarios
   initial begin
      for (int i = 0; i < NUM_POS; i++) begin
         lf = nx(lf);
         tab[32*i+:32] = {lf, ~lf};
      end
      repeat (4) @(posedge clk);
      #2 rst = 1'b0;
      for (int k = 0; k < 8; k++) begin
         lf = nx(lf);
         s = (k < 3) ? 3'(k) : 3'(k) ^ lf[2:0];
         m.fire(s);
         tick();
         chk(mo, {1'b1, s, tab[32*s+:32]});
         tick();
         chk(mo.start_move, 1'b0);
         m.drop();
         tick();
      end
      for (int i = 0; i < 16; i++) begin
         md = sdi_mode_e'(i[3:2]);
         cm = i[1:0];
         clr = 1'b1;
         tick();
         chk(co, exp_clr(md, cm));
         clr = 1'b0;
         tick();
         chk(co, 3'h0);
      end
      md = SDI_MODE_INT_POS;
      clr = 1'b1;
      tick();
      clr = 1'b0;
      tick();
      chk(rch, 1'b0);
      stp = 1'b1;
      tick();
      tick();
      chk(rch, 1'b1);
      md = SDI_MODE_SPEED;
      m.fire(3'h5);
      tick();
      chk(mo.start_move, 1'b0);
      m.drop();
      chk(rch, 1'b1);
      md = SDI_MODE_INT_POS;
      m.fire(3'h2);
      tick();
      chk(mo.start_move, 1'b1);
      tick();
      chk(rch, 1'b0);
      m.drop();
      for (int i = 0; i < 40; i++) begin
         lf = nx(lf);
         md = sdi_mode_e'(lf[1:0]);
         {lck, inv, pau, tle, sle} = lf[6:2];
         spd = {12'h000, lf[11:8]} + 16'h000C;
         tick();
         chk({hld, ivd, cpa, tla, sla}, {lck && spd < thr, inv && md != SDI_MODE_EXT_PULSE,
            pau && md == SDI_MODE_INT_POS, tle && md != SDI_MODE_TORQUE,
            sle && md == SDI_MODE_TORQUE});
      end
      end_sim();
   end
endmodule
